// ==== pkg/mad_pkg.sv ====
`default_nettype none
package mad_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ        = 10_000_000; // Core clock rate in Hz
	localparam int unsigned SEC_S         = 1;          // Base tick period in seconds
	localparam int unsigned SEC_CYCLES    = CLK_HZ * SEC_S;
	localparam int unsigned HOUR_S        = 3600;       // One hour in seconds
	localparam int unsigned KEY_HOLD_S    = 1;          // Set-key hold time in seconds
	localparam int unsigned BLINK_MS      = 500;        // Hz indicator half period in ms
	localparam int unsigned BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_MS;

	// Counter ranges
	localparam logic [15:0] HOUR_MAX      = 16'hffff;   // Hour counters wrap past this
	localparam logic [31:0] PANEL_MAX     = 32'h0000_270f; // 9999, four panel digits
	localparam logic [31:0] HH_MAX        = 32'h0001_869f; // 99999, five handheld digits
	localparam logic [39:0] KWH_MAX_SHORT = 40'h00_0000_270f; // 9999 kWh
	localparam logic [39:0] KWH_MAX_LONG  = 40'h00_0000_ffff; // 65535 kWh
	localparam logic [39:0] CENT_PER_KWH  = 40'h00_0000_0064; // 0.01 kWh steps per kWh
	localparam logic [3:0]  HOUR_DIV      = 4'ha;       // Hours per panel count (1h = 0.001)

	// Monitor selection codes
	localparam logic [7:0]  SEL_SEQ       = 8'h00;      // Plain sequence stepping
	localparam logic [7:0]  SEL_THERMAL   = 8'h0a;      // Combined thermal load
	localparam logic [7:0]  SEL_ENERG_H   = 8'h14;      // Energization hours
	localparam logic [7:0]  SEL_RUN_H     = 8'h17;      // Run hours
	localparam logic [7:0]  SEL_ENERGY    = 8'h19;      // Cumulative energy
	localparam logic [7:0]  SEL_TERMINAL  = 8'h37;      // Terminal state monitor
	localparam logic [7:0]  SEL_SETFREQ   = 8'h64;      // Set frequency while stopped

	// Parameter values
	localparam logic [13:0] CLR_DO        = 14'h0000;   // Write that clears the energy
	localparam logic [13:0] CLR_SHORT     = 14'h000a;   // 10: short range
	localparam logic [13:0] CLR_LONG      = 14'h270f;   // 9999: long range, reset value
	localparam logic [13:0] SHIFT_WRAP    = 14'h270f;   // 9999: wrap mode, no shift
	localparam logic [13:0] SHIFT_MAX     = 14'h0004;   // Largest clamp-mode shift

	// Panel decimal point positions
	localparam logic [1:0]  DP_NONE       = 2'h0;
	localparam logic [1:0]  DP_TENTH      = 2'h1;
	localparam logic [1:0]  DP_CENT       = 2'h2;
	localparam logic [1:0]  DP_MILLI      = 2'h3;

	// Panel content kinds
	typedef enum logic [1:0] {
		PM_NUMBER = 2'h0,
		PM_DASHES = 2'h1,
		PM_TERMS  = 2'h2,
		PM_TUNING = 2'h3
	} mad_pmode_t;

	// Panel sequence positions, one-hot
	typedef enum logic [3:0] {
		POS_FREQ  = 4'b0001,
		POS_VOLT  = 4'b0010,
		POS_THIRD = 4'b0100,
		POS_FAULT = 4'b1000
	} mad_pos_t;
endpackage
`default_nettype wire

// ==== design/mad_monitor.sv ====
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mad_monitor #(
	parameter int unsigned SEC_CYCLES   = mad_pkg::SEC_CYCLES,
	parameter int unsigned HOUR_SECS    = mad_pkg::HOUR_S,
	parameter int unsigned BLINK_CYCLES = mad_pkg::BLINK_CYCLES
) (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// Drive state
	input  wire logic        running,
	input  wire logic        output_stop_input,
	input  wire logic        fault_active,
	input  wire logic        tuning_active,
	// Measured quantities
	input  wire logic [15:0] out_freq,
	input  wire logic [15:0] cmd_freq,
	input  wire logic [15:0] freq_max,
	input  wire logic [15:0] freq_min,
	input  wire logic [15:0] jump_lo,
	input  wire logic [15:0] jump_hi,
	input  wire logic [15:0] out_current,
	input  wire logic [15:0] out_voltage,
	input  wire logic [15:0] out_power,
	input  wire logic [15:0] motor_thermal,
	input  wire logic [15:0] trans_thermal,
	input  wire logic [15:0] tuning_status,
	input  wire logic [15:0] fault_code,
	input  wire logic [15:0] other_monitor,
	input  wire logic [7:0]  in_terminals,
	input  wire logic [7:0]  out_terminals,
	// Panel key and power-on position
	input  wire logic        set_key,
	input  wire logic [3:0]  first_pos_init,
	// Parameters
	input  wire logic [7:0]  monitor_select_param,
	input  wire logic        energy_clear_wr,
	input  wire logic [13:0] energy_clear_wdata,
	input  wire logic [13:0] energy_digit_shift_param,
	// Panel outputs
	output logic [15:0]      panel_value,
	output logic [1:0]       panel_dp,
	output logic [1:0]       panel_mode,
	output logic             hz_led,
	output logic [3:0]       panel_pos,
	output logic [3:0]       first_pos,
	// Handheld unit and serial link
	output logic [16:0]      handheld_unit_energy,
	output logic [1:0]       handheld_unit_dp,
	output logic [15:0]      comm_energy_kwh,
	output logic [15:0]      comm_energy_cent,
	// Counters and parameter readback
	output logic [15:0]      energ_hours,
	output logic [15:0]      run_hours,
	output logic [13:0]      energy_clear_param
);
	initial begin
		if (SEC_CYCLES < 2 || HOUR_SECS < 2 || BLINK_CYCLES < 2)
			$error("mad_monitor: time base parameters too small");
	end

	// Divide by a power of ten; shared by every energy view
	function automatic logic [39:0] div10p(input logic [39:0] x, input logic [2:0] s);
		case (s)
			3'h0:    div10p = x;
			3'h1:    div10p = x / 40'd10;
			3'h2:    div10p = x / 40'd100;
			3'h3:    div10p = x / 40'd1000;
			default: div10p = x / 40'd10000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Time base
	logic [31:0] pre_r;          // Cycles into current second
	logic        sec_tick;       // One pulse per second
	logic [31:0] hsec_r;         // Seconds into current hour
	logic        hour_tick;      // One pulse per hour
	logic [31:0] rsec_r;         // Seconds of running not yet booked
	logic        running_out;    // Drive output really switching

	assign sec_tick    = ce && (pre_r == SEC_CYCLES - 1);
	assign hour_tick   = sec_tick && (hsec_r == HOUR_SECS - 1);
	assign running_out = running && !output_stop_input;

	// Second prescaler and hour divider from the core clock
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pre_r  <= 32'h0;
			hsec_r <= 32'h0;
		end else if (ce) begin
			pre_r <= sec_tick ? 32'h0 : pre_r + 32'h1;
			if (sec_tick)
				hsec_r <= hour_tick ? 32'h0 : hsec_r + 32'h1;
		end
	end

	// Hour counters; 16-bit add wraps past the top naturally
	always_ff @(posedge clk) begin
		if (!nrst) begin
			energ_hours <= 16'h0;
			run_hours   <= 16'h0;
			rsec_r      <= 32'h0;   // Reset drops partial run time
		end else if (ce) begin
			if (hour_tick)
				energ_hours <= energ_hours + 16'h1;
			if (sec_tick && running_out) begin
				if (rsec_r == HOUR_SECS - 1) begin
					rsec_r    <= 32'h0;
					run_hours <= run_hours + 16'h1;
				end else
					rsec_r <= rsec_r + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Energy accumulation
	logic [31:0] pacc_r;         // Power-seconds not yet worth 0.01 kWh
	logic [39:0] pend_r;         // 0.01 kWh units waiting for the hourly refresh
	logic [39:0] etot_r;         // Published total in 0.01 kWh
	logic [31:0] psum;           // Carried power-seconds plus this second's sample
	logic [39:0] pquo;           // Whole 0.01 kWh units held in psum
	logic        wrap_mode;      // Shift parameter asks for wrap-around
	logic [2:0]  shift;          // Effective decimal shift
	logic [39:0] emax;           // Largest total before clamp or wrap
	logic [39:0] esum;           // Total plus pending

	// Constant divider: costs area, but keeps up with any power at any time base
	assign psum      = pacc_r + {16'h0, out_power};
	assign pquo      = {8'h0, psum / HOUR_SECS};
	assign wrap_mode = energy_digit_shift_param == mad_pkg::SHIFT_WRAP;
	// Out-of-range shift values act as no shift
	assign shift     = (energy_digit_shift_param <= mad_pkg::SHIFT_MAX) ? energy_digit_shift_param[2:0] : 3'h0;
	assign esum      = etot_r + pend_r;

	// Range follows the clear parameter; shift widens it by powers of ten
	always_comb begin
		emax = (energy_clear_param == mad_pkg::CLR_SHORT) ? mad_pkg::KWH_MAX_SHORT : mad_pkg::KWH_MAX_LONG;
		emax = (emax + 40'h1) * mad_pkg::CENT_PER_KWH - 40'h1;
		for (int i = 0; i < 4; i++)
			if (i < shift)
				emax = (emax + 40'h1) * 40'd10 - 40'h1;
	end

	// Integrate power each second, book the total once an hour
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pacc_r <= 32'h0;
			pend_r <= 40'h0;
			etot_r <= 40'h0;
		end else if (ce) begin
			if (energy_clear_wr && energy_clear_wdata == mad_pkg::CLR_DO) begin
				pacc_r <= 32'h0;
				pend_r <= 40'h0;
				etot_r <= 40'h0;
			end else begin
				// Whole units are booked once a second; the remainder carries over
				if (sec_tick)
					pacc_r <= psum % HOUR_SECS;
				if (hour_tick) begin
					pend_r <= pquo;
					if (esum <= emax)
						etot_r <= esum;
					else if (wrap_mode)
						etot_r <= esum - emax - 40'h1;
					else
						etot_r <= emax;
				end else if (sec_tick)
					pend_r <= pend_r + pquo;
			end
		end
	end

	// Clear parameter keeps its range setting; a zero write never sticks
	always_ff @(posedge clk) begin
		if (!nrst)
			energy_clear_param <= mad_pkg::CLR_LONG;
		else if (ce && energy_clear_wr &&
			(energy_clear_wdata == mad_pkg::CLR_SHORT || energy_clear_wdata == mad_pkg::CLR_LONG))
			energy_clear_param <= energy_clear_wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Set key: short press steps, one-second hold marks first monitor
	mad_pkg::mad_pos_t pos_r;    // Current panel position
	logic        key_r;          // Key level last cycle
	logic [31:0] hold_r;         // Cycles the key has been held
	logic        held_r;         // Hold already acted on this press
	mad_pkg::mad_pos_t pos_next; // Following position in the sequence

	always_comb begin
		case (pos_r)
			mad_pkg::POS_FREQ:  pos_next = mad_pkg::POS_VOLT;
			mad_pkg::POS_VOLT:  pos_next = mad_pkg::POS_THIRD;
			mad_pkg::POS_THIRD: pos_next = mad_pkg::POS_FAULT;
			default:            pos_next = mad_pkg::POS_FREQ;
		endcase
	end

	// Power-on position is taken from the retained value at reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pos_r     <= mad_pkg::mad_pos_t'(first_pos_init);
			first_pos <= first_pos_init;
			key_r     <= 1'b0;
			hold_r    <= 32'h0;
			held_r    <= 1'b0;
		end else if (ce) begin
			key_r <= set_key;
			if (set_key) begin
				if (hold_r == SEC_CYCLES * mad_pkg::KEY_HOLD_S - 1 && !held_r) begin
					first_pos <= pos_r;
					held_r    <= 1'b1;
				end else if (!held_r)
					hold_r <= hold_r + 32'h1;
			end else begin
				// Step on release, so a long hold does not also step
				if (key_r && !held_r)
					pos_r <= pos_next;
				hold_r <= 32'h0;
				held_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Displayed quantity selection
	logic [15:0] fault_freq_r;   // Output frequency when the fault struck
	logic        fault_q_r;      // Fault level last cycle
	logic [31:0] blink_r;        // Hz indicator blink timer
	logic        blink_ph_r;     // Blink phase
	logic [15:0] set_freq;       // Frequency a start would produce
	logic        stopped;        // Display treats the drive as stopped
	logic [39:0] eshow;          // Energy after digit shift
	logic [15:0] sel_val;        // Third-position numeric value
	logic [1:0]  sel_dp;
	logic [1:0]  sel_mode;
	logic [31:0] num;            // Numeric value before panel range check
	logic [1:0]  num_dp;
	logic [1:0]  pmode;

	assign stopped = !running || output_stop_input;
	assign eshow   = div10p(etot_r, shift);

	// Limits first, then a point inside a jump band parks on its low edge
	always_comb begin
		set_freq = cmd_freq;
		if (set_freq > freq_max)
			set_freq = freq_max;
		if (set_freq < freq_min)
			set_freq = freq_min;
		if (set_freq > jump_lo && set_freq < jump_hi)
			set_freq = jump_lo;
	end

	// Capture frequency on the rising edge of a fault
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault_q_r    <= 1'b0;
			fault_freq_r <= 16'h0;
		end else if (ce) begin
			fault_q_r <= fault_active;
			if (fault_active && !fault_q_r)
				fault_freq_r <= out_freq;
		end
	end

	// Third-position monitor chosen by the selection code
	always_comb begin
		sel_dp   = mad_pkg::DP_NONE;
		sel_mode = mad_pkg::PM_NUMBER;
		case (monitor_select_param)
			mad_pkg::SEL_SEQ, mad_pkg::SEL_SETFREQ:
				sel_val = out_current;
			mad_pkg::SEL_THERMAL:
				sel_val = (motor_thermal > trans_thermal) ? motor_thermal : trans_thermal;
			mad_pkg::SEL_ENERG_H: begin
				sel_val = energ_hours / {12'h0, mad_pkg::HOUR_DIV};
				sel_dp  = mad_pkg::DP_CENT;                           // 65530h reads 65.53
			end
			mad_pkg::SEL_RUN_H: begin
				sel_val = run_hours / {12'h0, mad_pkg::HOUR_DIV};
				sel_dp  = mad_pkg::DP_CENT;
			end
			mad_pkg::SEL_TERMINAL: begin
				sel_val  = {in_terminals, out_terminals};
				sel_mode = mad_pkg::PM_TERMS;
			end
			default:
				sel_val = other_monitor;
		endcase
	end

	// Panel content for the current position
	always_comb begin
		num    = 32'h0;
		num_dp = mad_pkg::DP_NONE;
		pmode  = mad_pkg::PM_NUMBER;
		case (pos_r)
			mad_pkg::POS_FREQ:
				// First fault cycle: the capture is not in the register yet
				if (fault_active)
					num = {16'h0, fault_q_r ? fault_freq_r : out_freq};
				else if (monitor_select_param == mad_pkg::SEL_SETFREQ && stopped)
					num = {16'h0, set_freq};
				else
					num = {16'h0, out_freq};
			mad_pkg::POS_VOLT:
				num = {16'h0, out_voltage};
			mad_pkg::POS_THIRD:
				if (monitor_select_param == mad_pkg::SEL_ENERGY) begin
					if (eshow <= {8'h0, mad_pkg::PANEL_MAX}) begin
						num    = eshow[31:0];
						num_dp = mad_pkg::DP_CENT;
					end else if (eshow <= {8'h0, mad_pkg::PANEL_MAX} * 40'd10 + 40'd9) begin
						num    = div10p(eshow, 3'h1)[31:0];
						num_dp = mad_pkg::DP_TENTH;
					end else
						num    = div10p(eshow, 3'h2)[31:0];
				end else begin
					num    = {16'h0, sel_val};
					num_dp = sel_dp;
					pmode  = sel_mode;
				end
			default:
				num = {16'h0, fault_code};
		endcase
		if (tuning_active) begin
			num    = {16'h0, tuning_status};
			num_dp = mad_pkg::DP_NONE;
			pmode  = mad_pkg::PM_TUNING;
		end else if (pmode == mad_pkg::PM_NUMBER && num > mad_pkg::PANEL_MAX)
			pmode = mad_pkg::PM_DASHES;
	end

	// Hz indicator blink timer runs continuously
	always_ff @(posedge clk) begin
		if (!nrst) begin
			blink_r    <= 32'h0;
			blink_ph_r <= 1'b0;
		end else if (ce) begin
			if (blink_r == BLINK_CYCLES - 1) begin
				blink_r    <= 32'h0;
				blink_ph_r <= !blink_ph_r;
			end else
				blink_r <= blink_r + 32'h1;
		end
	end

	// Registered panel outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			panel_value <= 16'h0;
			panel_dp    <= mad_pkg::DP_NONE;
			panel_mode  <= mad_pkg::PM_NUMBER;
			panel_pos   <= mad_pkg::POS_FREQ;
			hz_led      <= 1'b0;
		end else if (ce) begin
			panel_value <= num[15:0];
			panel_dp    <= num_dp;
			panel_mode  <= pmode;
			panel_pos   <= pos_r;
			// Flash only while stopped on set-frequency display
			hz_led      <= (pos_r == mad_pkg::POS_FREQ) &&
				!(monitor_select_param == mad_pkg::SEL_SETFREQ && stopped && !blink_ph_r);
		end
	end

	// Handheld unit and serial link energy views
	always_ff @(posedge clk) begin
		if (!nrst) begin
			handheld_unit_energy <= 17'h0;
			handheld_unit_dp     <= mad_pkg::DP_CENT;
			comm_energy_kwh      <= 16'h0;
			comm_energy_cent     <= 16'h0;
		end else if (ce) begin
			if (eshow <= {8'h0, mad_pkg::HH_MAX}) begin
				handheld_unit_energy <= eshow[16:0];
				handheld_unit_dp     <= mad_pkg::DP_CENT;
			end else if (eshow <= {8'h0, mad_pkg::HH_MAX} * 40'd10 + 40'd9) begin
				handheld_unit_energy <= div10p(eshow, 3'h1)[16:0];
				handheld_unit_dp     <= mad_pkg::DP_TENTH;
			end else begin
				handheld_unit_energy <= div10p(eshow, 3'h2)[16:0];
				handheld_unit_dp     <= mad_pkg::DP_NONE;
			end
			comm_energy_kwh  <= div10p(eshow, 3'h2)[15:0];
			comm_energy_cent <= eshow[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_hour_step;
		ce && hour_tick;
	endsequence

	a_energ_hour_step: assert property (@(posedge clk) disable iff (!nrst)
		s_hour_step |=> energ_hours == $past(energ_hours) + 16'h1)
		else $error("energization hours did not step on hour tick");
	a_run_hold_stop: assert property (@(posedge clk) disable iff (!nrst)
		!running |=> run_hours == $past(run_hours))
		else $error("run hours advanced while stopped");
	a_dash_range: assert property (@(posedge clk) disable iff (!nrst)
		panel_mode == mad_pkg::PM_NUMBER |-> panel_value <= mad_pkg::PANEL_MAX[15:0])
		else $error("panel shows a number above 9999");
	a_clear_total: assert property (@(posedge clk) disable iff (!nrst)
		ce && energy_clear_wr && energy_clear_wdata == mad_pkg::CLR_DO |=> etot_r == 40'h0)
		else $error("energy not cleared by zero write");
	a_clear_readback: assert property (@(posedge clk) disable iff (!nrst)
		energy_clear_param == mad_pkg::CLR_SHORT || energy_clear_param == mad_pkg::CLR_LONG)
		else $error("clear parameter reads an illegal value");
	a_energy_range: assert property (@(posedge clk) disable iff (!nrst)
		$changed(etot_r) && etot_r != 40'h0 |-> etot_r <= emax)
		else $error("energy total above its maximum");
	a_energy_hourly: assert property (@(posedge clk) disable iff (!nrst)
		ce && !hour_tick && !energy_clear_wr |=> $stable(etot_r))
		else $error("energy total changed between hourly refreshes");
	a_tuning_first: assert property (@(posedge clk) disable iff (!nrst)
		ce && tuning_active |=> panel_mode == mad_pkg::PM_TUNING)
		else $error("tuning status not shown during tuning");
	a_fault_freq: assert property (@(posedge clk) disable iff (!nrst)
		ce && fault_active && pos_r == mad_pkg::POS_FREQ && !tuning_active |=> panel_value == fault_freq_r)
		else $error("fault frequency not shown during fault");
	a_thermal_max: assert property (@(posedge clk) disable iff (!nrst)
		ce && monitor_select_param == mad_pkg::SEL_THERMAL && pos_r == mad_pkg::POS_THIRD && !tuning_active
		&& sel_val <= mad_pkg::PANEL_MAX[15:0]
		|=> panel_value >= $past(motor_thermal) && panel_value >= $past(trans_thermal))
		else $error("thermal monitor not the larger value");
endmodule
`default_nettype wire

// ==== dv/mad_panel_model.sv ====
`default_nettype none
////////////////////////////////////////
// Operator at the panel: presses the set key
module mad_panel_model (
	// Clock
	input  wire logic clk,
	// Key towards the block
	output var  logic set_key
);
	timeunit 1ns;
	timeprecision 1ns;
	// Key released at power-up
	initial set_key = 1'h0;
	// Hold the key n cycles; a short hold steps, a long one stores
	task automatic press(input int n);
		@(negedge clk) set_key = 1'h1;
		repeat (n) @(negedge clk);
		set_key = 1'h0;
		// Let the step reach panel_pos before the next press
		repeat (3) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
////////////////////////////////////////
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus, changed at falling edges
	logic        clk = 1'h0, nrst = 1'h0, running = 1'h0, stop_in = 1'h0;
	logic        fault = 1'h0, tune = 1'h0, clr_wr = 1'h0, set_key;
	logic [15:0] fout = '0, fcmd = '0, pwr = '0, mth = '0, tth = '0, tstat = '0, oth = '0, fcode = '0;
	logic [15:0] fmax = 16'h1388, fmin = 16'h03e8, jlo = 16'h0bb8, jhi = 16'h0dac, cur = '0, volt = '0;
	logic [7:0]  in_t = '0, out_t = '0, sel = '0;
	logic [13:0] clr_d = '0, shft = '0;
	logic [3:0]  pinit = 4'h1;
	// Observed outputs
	logic [15:0] pval, ckwh, ccent, eh, rh;
	logic [16:0] hh;
	logic [13:0] cpar;
	logic [3:0]  ppos, fpos;
	logic [1:0]  pdp, pmode, hdp;
	logic        hz;
	int          num_errors = 0, checks_done = 0, seed = 75, cyc = 0;
	int          sh[4] = '{1, 2, 4, 0};

	always #50 clk = ~clk;
	// Cycles since reset release, to reckon elapsed hours
	always @(posedge clk) if (nrst) cyc <= cyc + 1;

	// Short time base: second = 4 cycles, hour = 16 cycles
	mad_monitor #(.SEC_CYCLES(4), .HOUR_SECS(4), .BLINK_CYCLES(4)) dut (
		.clk(clk), .nrst(nrst), .ce(1'h1), .running(running), .output_stop_input(stop_in),
		.fault_active(fault), .tuning_active(tune), .out_freq(fout), .cmd_freq(fcmd),
		.freq_max(fmax), .freq_min(fmin), .jump_lo(jlo), .jump_hi(jhi), .out_current(cur),
		.out_voltage(volt), .out_power(pwr), .motor_thermal(mth), .trans_thermal(tth),
		.tuning_status(tstat), .fault_code(fcode), .other_monitor(oth), .in_terminals(in_t),
		.out_terminals(out_t), .set_key(set_key), .first_pos_init(pinit), .monitor_select_param(sel),
		.energy_clear_wr(clr_wr), .energy_clear_wdata(clr_d), .energy_digit_shift_param(shft),
		.panel_value(pval), .panel_dp(pdp), .panel_mode(pmode), .hz_led(hz), .panel_pos(ppos),
		.first_pos(fpos), .handheld_unit_energy(hh), .handheld_unit_dp(hdp), .comm_energy_kwh(ckwh),
		.comm_energy_cent(ccent), .energ_hours(eh), .run_hours(rh), .energy_clear_param(cpar));
	mad_panel_model pnl (.clk(clk), .set_key(set_key));

	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %0h got %0h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One-cycle write pulse to the clear parameter
	task automatic wclr(input logic [13:0] v);
		clr_d = v;
		clr_wr = 1'h1;
		step(1);
		clr_wr = 1'h0;
		step(3);
	endtask
	// Reference set frequency: max, then min, then jump band
	function automatic int setf(input int c);
		int v;
		v = c > int'(fmax) ? int'(fmax) : c;
		v = v < int'(fmin) ? int'(fmin) : v;
		return (v > int'(jlo) && v < int'(jhi)) ? int'(jlo) : v;
	endfunction
	// Reference energy views for a displayed value e in 0.01 kWh
	task automatic echk(input int e);
		chk("panel_value", e <= 9999 ? e : e <= 99999 ? e / 10 : e / 100, pval);
		chk("panel_dp", e <= 9999 ? 2 : e <= 99999 ? 1 : 0, pdp);
		chk("hh_energy", e <= 99999 ? e : e <= 999999 ? e / 10 : e / 100, hh);
		chk("hh_dp", e <= 99999 ? 2 : e <= 999999 ? 1 : 0, hdp);
		chk("comm_kwh", (e / 100) & 32'hffff, ckwh);
		chk("comm_cent", e & 32'hffff, ccent);
	endtask
	// Blinking shows both levels in 12 cycles, steady shows only lit
	task automatic hzw(input logic blink);
		int n;
		n = 0;
		repeat (12) begin
			step(1);
			n += int'(hz);
		end
		chk("hz_led", blink ? 1 : 12, blink ? 32'(n > 0 && n < 12) : 32'(n));
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard: the sequence needs about 670 cycles
	initial begin
		#(5000 * 100);
		num_errors++;
		final_report;
	end

	////////////////////////////////////////
	initial begin
		step(3);
		nrst = 1'h1;
		step(2);
		chk("clr_param", 14'h270f, cpar);
		chk("first_pos", 4'h1, fpos);
		// Stopped, code 100: set frequency, first case inside the jump band
		sel = 8'h64;
		for (int i = 0; i < 9; i++) begin
			fmax = i < 5 ? 16'h1388 : 16'h0fa0;
			fcmd = i == 0 ? 16'h0c80 : 16'($random(seed)) & 16'h1fff;
			step(3);
			chk("set_freq", setf(int'(fcmd)), pval);
		end
		hzw(1'h1);
		running = 1'h1;
		fout = 16'h0bb8;
		step(3);
		chk("out_freq", fout, pval);
		hzw(1'h0);
		// Output stop while running displays as stopped
		stop_in = 1'h1;
		step(3);
		chk("stop_freq", setf(int'(fcmd)), pval);
		stop_in = 1'h0;
		// Frequency moves after the fault: the captured one must stay
		fault = 1'h1;
		step(1);
		fout = 16'h0123;
		step(3);
		chk("fault_freq", 16'h0bb8, pval);
		fault = 1'h0;
		// Short presses step round the sequence, wrapping at the end
		sel = 8'h00;
		volt = 16'($random(seed)) & 16'h1fff;
		cur = 16'($random(seed)) & 16'h1fff;
		fcode = 16'($random(seed)) & 16'h1fff;
		for (int i = 1; i < 5; i++) begin
			pnl.press(1);
			chk("panel_pos", 4'h1 << (i % 4), ppos);
			chk("pos_value", i == 1 ? volt : i == 2 ? cur : i == 3 ? fcode : fout, pval);
		end
		pnl.press(1);
		pnl.press(1);
		pnl.press(6);
		chk("first_pos", 4'h4, fpos);
		chk("panel_pos", 4'h4, ppos);
		// Third position content per selection code
		sel = 8'h0a;
		repeat (4) begin
			mth = 16'($random(seed)) & 16'h0fff;
			tth = 16'($random(seed)) & 16'h0fff;
			step(3);
			chk("thermal", mth > tth ? mth : tth, pval);
		end
		in_t = 8'ha5;
		out_t = 8'h3c;
		sel = 8'h37;
		step(3);
		chk("terminals", 16'ha53c, pval);
		chk("term_mode", 2'h2, pmode);
		sel = 8'h05;
		oth = 16'h04d2;
		step(3);
		chk("other", 16'h04d2, pval);
		oth = 16'h2710;
		step(3);
		chk("dash_mode", 2'h1, pmode);
		tune = 1'h1;
		tstat = 16'h0007;
		step(3);
		chk("tuning", 16'h0007, pval);
		chk("tune_mode", 2'h3, pmode);
		tune = 1'h0;
		// Short range, full power until the total clamps at 9999.99 kWh
		sel = 8'h19;
		wclr(14'h000a);
		chk("clr_param", 14'h000a, cpar);
		pwr = 16'hffff;
		step(400);
		pwr = 16'h0000;
		step(40);
		echk(999999);
		foreach (sh[i]) begin
			shft = 14'(sh[i]);
			step(3);
			echk(999999 / 10 ** sh[i]);
		end
		// Wrap mode: next hour's energy restarts the total from zero
		shft = 14'h270f;
		pwr = 16'hffff;
		step(20);
		pwr = 16'h0000;
		step(4);
		chk("wrap_kwh", 1, 32'(ckwh < 16'd1311));
		step(40);
		wclr(14'h0000);
		chk("clr_cent", 0, ccent);
		chk("clr_kwh", 0, ckwh);
		chk("clr_param", 14'h000a, cpar);
		wclr(14'h270f);
		wclr(14'h0005);
		chk("clr_param", 14'h270f, cpar);
		chk("energ_hours", 1, 32'(eh >= cyc / 16 - 1 && eh <= cyc / 16));
		chk("run_hours", 1, 32'(rh < eh));
		// Hour monitors on the panel: ten hours a count, two decimals shown
		sel = 8'h14;
		step(3);
		chk("ehours_panel", 1, 32'(pval == eh / 16'd10 || pval == (eh - 16'd1) / 16'd10));
		chk("hours_dp", 2, pdp);
		sel = 8'h17;
		step(3);
		chk("rhours_panel", 1, 32'(pval == rh / 16'd10 || pval == (rh - 16'd1) / 16'd10));
		final_report;
	end
endmodule
`default_nettype wire
